// >>> verilog/cdt_pkg.sv
/*
  cdt_pkg: register indices, field positions, reset values and the
  debug-halt state type of the down-counting cpu timer.
  assumes: the register word index times four is the apb byte address.
*/
package cdt_pkg;
  // register word indices
  localparam logic [3:0] IDX_COUNT_LOW  = 4'h0;
  localparam logic [3:0] IDX_COUNT_HIGH = 4'h1;
  localparam logic [3:0] IDX_PERIOD_LOW = 4'h2;
  localparam logic [3:0] IDX_PERIOD_HI  = 4'h3;
  localparam logic [3:0] IDX_CONTROL    = 4'h4;
  localparam logic [3:0] IDX_PRESC_LOW  = 4'h6;
  localparam logic [3:0] IDX_PRESC_HIGH = 4'h7;
  localparam logic [3:0] IDX_IRQ_STATUS = 4'h8;
  localparam logic [3:0] IDX_IRQ_CLEAR  = 4'h9;
  localparam logic [3:0] IDX_IRQ_ENABLE = 4'hA;
  // control register bit positions
  localparam int TCR_ZERO_FLAG = 15;
  localparam int TCR_IRQ_EN    = 14;
  localparam int TCR_FREE_RUN  = 11;
  localparam int TCR_SOFT_STOP = 10;
  localparam int TCR_RELOAD    = 5;
  localparam int TCR_STOP      = 4;
  // prescale register fields: divide byte low, live count byte high
  localparam int PRE_DIV_LSB = 0;
  localparam int PRE_CNT_LSB = 8;
  // event bits of the interrupt status register
  localparam int EVT_ZERO = 0;
  localparam int EVT_HALT = 1;
  localparam int EVT_W    = 2;
  // reset values
  localparam logic [15:0] COUNT_RST      = 16'h0000;
  localparam logic [15:0] PERIOD_LOW_RST = 16'hFFFF;
  localparam logic [15:0] PERIOD_HI_RST  = 16'h0000;
  localparam logic [15:0] DIVIDE_RST     = 16'h0000;
  localparam logic        CTRL_BIT_RST   = 1'b0;
  // debug-halt state
  typedef enum logic [0:0] {
    EMU_RUN  = 1'b0,
    EMU_HELD = 1'b1
  } cdt_emu_t;
endpackage

// >>> verilog/cdt_prescaler.sv
/*
  cdt_prescaler: divide-down counter giving one tick every divide+1
  clocks while run is high.
  assumes: load and divide are synchronous to clk.
*/
`timescale 1ns/1ps
module cdt_prescaler #(
  parameter int DIV_W = 16
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             run,
  input  wire logic             load,
  input  wire logic [DIV_W-1:0] divide,
  output logic                  tick,
  output logic      [DIV_W-1:0] value
);
  // refuse widths the register map cannot hold
  if (DIV_W < 1 || DIV_W > 16) begin : g_bad_w
    $error("cdt_prescaler: DIV_W must be 1..16");
  end

  logic [DIV_W-1:0] psc_reg;   // live divide count
  logic [DIV_W-1:0] psc_next;  // next count

  // tick when the count runs out while running
  assign tick  = run && (psc_reg == '0);
  assign value = psc_reg;

  // reload on tick or on request, else count down
  always_comb begin
    psc_next = psc_reg;
    if (load || tick) begin
      psc_next = divide;
    end else if (run) begin
      psc_next = psc_reg - 1'b1;
    end
  end

  // count register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      psc_reg <= '0;
    end else begin
      psc_reg <= psc_next;
    end
  end
endmodule // cdt_prescaler

// >>> verilog/cdt_irq_status.sv
/*
  cdt_irq_status: sticky event bits, enable mask and one level
  interrupt line.
  assumes: strobes are single-cycle accepted bus writes.
*/
`timescale 1ns/1ps
module cdt_irq_status #(
  parameter int EW = 2
) (
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire logic [EW-1:0] event_in,
  input  wire logic          clr_wr,
  input  wire logic          en_wr,
  input  wire logic [EW-1:0] wdata,
  output logic      [EW-1:0] status,
  output logic      [EW-1:0] enable,
  output logic               irq
);
  if (EW < 1 || EW > 16) begin : g_bad_w
    $error("cdt_irq_status: EW must be 1..16");
  end

  logic [EW-1:0] status_reg;   // sticky events
  logic [EW-1:0] enable_reg;   // mask
  logic          irq_reg;      // level output
  logic [EW-1:0] status_next;
  logic [EW-1:0] enable_next;

  // set wins over a clear in the same cycle
  assign status_next = event_in | (status_reg & ~(clr_wr ? wdata : '0));
  assign enable_next = en_wr ? wdata : enable_reg;
  assign status      = status_reg;
  assign enable      = enable_reg;
  assign irq         = irq_reg;

  // state registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_reg <= '0;
      enable_reg <= '0;
      irq_reg    <= 1'b0;
    end else begin
      status_reg <= status_next;
      enable_reg <= enable_next;
      irq_reg    <= |(status_next & enable_next);
    end
  end
endmodule // cdt_irq_status

// >>> verilog/cdt_timer.sv
/*
  cdt_timer: one 32-bit down-counting cpu timer with prescaler,
  period reload, zero flag, debug-halt modes and an apb register slave.
  assumes: apb master per apb3 signalling, all inputs synchronous
  to REF_CLK, DBG_HALT a level from the debug logic.
*/
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
module cdt_timer (
  input  wire logic        REF_CLK,
  input  wire logic        ARST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        DBG_HALT,
  output logic             TIMER_IRQ_PULSE,
  output logic             IRQ
);
  // word index hit on an aligned in-range address
  function automatic logic hit(input logic [7:0] a, input logic [3:0] idx);
    return (a[7:6] == 2'b00) && (a[5:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  // bus state
  logic        pready_reg;    // access-phase ready
  logic        pslverr_reg;   // unmapped answer
  logic [31:0] prdata_reg;    // read data
  // timer state
  logic [31:0] count_reg;     // live count
  logic [31:0] count_next;
  logic [31:0] period_reg;    // reload value
  logic [31:0] period_next;
  logic [15:0] divide_reg;    // prescale divide
  logic [15:0] divide_next;
  logic        flag_reg;      // zero flag
  logic        tie_reg;       // irq enable
  logic        free_reg;      // free run in debug halt
  logic        soft_reg;      // soft stop in debug halt
  logic        tss_reg;       // stop control
  logic        pulse_reg;     // timer_irq_pulse
  cdt_pkg::cdt_emu_t emu_reg; // debug-halt state
  cdt_pkg::cdt_emu_t emu_next;

  // bus decode
  wire         setup    = PSEL && !PENABLE;
  wire         acc      = PSEL && PENABLE && pready_reg;
  wire         wr       = acc && PWRITE;
  wire  [15:0] wd       = PWDATA[15:0];
  wire         h_cl     = hit(PADDR, cdt_pkg::IDX_COUNT_LOW);
  wire         h_ch     = hit(PADDR, cdt_pkg::IDX_COUNT_HIGH);
  wire         h_pl     = hit(PADDR, cdt_pkg::IDX_PERIOD_LOW);
  wire         h_ph     = hit(PADDR, cdt_pkg::IDX_PERIOD_HI);
  wire         h_tc     = hit(PADDR, cdt_pkg::IDX_CONTROL);
  wire         h_rl     = hit(PADDR, cdt_pkg::IDX_PRESC_LOW);
  wire         h_rh     = hit(PADDR, cdt_pkg::IDX_PRESC_HIGH);
  wire         h_is     = hit(PADDR, cdt_pkg::IDX_IRQ_STATUS);
  wire         h_ic     = hit(PADDR, cdt_pkg::IDX_IRQ_CLEAR);
  wire         h_ie     = hit(PADDR, cdt_pkg::IDX_IRQ_ENABLE);
  wire         mapped   = h_cl | h_ch | h_pl | h_ph | h_tc | h_rl | h_rh
                          | h_is | h_ic | h_ie;
  wire         wr_tcr   = wr && h_tc;
  wire         wr_cnt   = wr && (h_cl || h_ch);
  wire         wr_pre   = wr && (h_rl || h_rh);
  wire         reload   = wr_tcr && wd[cdt_pkg::TCR_RELOAD];

  // timer datapath wires
  wire         run;       // prescaler and counter enabled
  wire         tick;      // prescaler output
  wire  [15:0] psc_val;   // live prescale count
  wire         zero_evt;  // decrement lands on zero
  wire         halt_evt;  // debug hold entered
  wire  [1:0]  irq_stat;
  wire  [1:0]  irq_en;
  wire  [15:0] tcr_rd;
  wire  [15:0] rd_word;

  assign run      = !tss_reg && (emu_reg == cdt_pkg::EMU_RUN);
  assign zero_evt = tick && (count_reg == 32'h0000_0001);
  assign halt_evt = (emu_reg == cdt_pkg::EMU_RUN)
                    && (emu_next == cdt_pkg::EMU_HELD);

  // prescaler restarts from divide on a reload or divide write
  cdt_prescaler #(
    .DIV_W (16)
  ) u_presc (
    .clk    (REF_CLK),
    .arst_n (ARST_N),
    .run    (run),
    .load   (reload || wr_pre),
    .divide (divide_next),
    .tick   (tick),
    .value  (psc_val)
  );

  // sticky events, mask and level interrupt
  cdt_irq_status #(
    .EW (cdt_pkg::EVT_W)
  ) u_irq (
    .clk      (REF_CLK),
    .arst_n   (ARST_N),
    .event_in ({halt_evt, zero_evt && tie_reg}),
    .clr_wr   (wr && h_ic),
    .en_wr    (wr && h_ie),
    .wdata    (wd[1:0]),
    .status   (irq_stat),
    .enable   (irq_en),
    .irq      (IRQ)
  );

  // count: tick, then software writes, reload trigger last
  always_comb begin
    count_next = count_reg;
    if (tick) begin
      if (count_reg == 32'h0000_0000) begin
        count_next = period_reg;
      end else begin
        count_next = count_reg - 32'h0000_0001;
      end
    end
    if (wr && h_cl) begin
      count_next[15:0] = wd;
    end
    if (wr && h_ch) begin
      count_next[31:16] = wd;
    end
    if (reload) begin
      count_next = period_reg;
    end
  end

  // period halves and divide bytes
  always_comb begin
    period_next = period_reg;
    divide_next = divide_reg;
    if (wr && h_pl) begin
      period_next[15:0] = wd;
    end
    if (wr && h_ph) begin
      period_next[31:16] = wd;
    end
    if (wr && h_rl) begin
      divide_next[7:0] = wd[cdt_pkg::PRE_DIV_LSB +: 8];
    end
    if (wr && h_rh) begin
      divide_next[15:8] = wd[cdt_pkg::PRE_DIV_LSB +: 8];
    end
  end

  // debug halt: hard stop after any decrement, soft after zero
  always_comb begin
    emu_next = emu_reg;
    case (emu_reg)
      cdt_pkg::EMU_RUN: begin
        if (DBG_HALT && !free_reg && tick && (!soft_reg || zero_evt)) begin
          emu_next = cdt_pkg::EMU_HELD;
        end
      end
      cdt_pkg::EMU_HELD: begin
        if (!DBG_HALT || free_reg) begin
          emu_next = cdt_pkg::EMU_RUN;
        end
      end
      default: begin
        emu_next = cdt_pkg::EMU_RUN;
      end
    endcase
  end

  // control register image; reload bit reads zero
  assign tcr_rd = (16'(flag_reg) << cdt_pkg::TCR_ZERO_FLAG)
                | (16'(tie_reg)  << cdt_pkg::TCR_IRQ_EN)
                | (16'(free_reg) << cdt_pkg::TCR_FREE_RUN)
                | (16'(soft_reg) << cdt_pkg::TCR_SOFT_STOP)
                | (16'(tss_reg)  << cdt_pkg::TCR_STOP);

  // read select; clear register and unmapped read zero
  assign rd_word = h_cl ? count_reg[15:0] :
                   h_ch ? count_reg[31:16] :
                   h_pl ? period_reg[15:0] :
                   h_ph ? period_reg[31:16] :
                   h_tc ? tcr_rd :
                   h_rl ? {psc_val[7:0], divide_reg[7:0]} :
                   h_rh ? {psc_val[15:8], divide_reg[15:8]} :
                   h_is ? {14'h0000, irq_stat} :
                   h_ie ? {14'h0000, irq_en} : 16'h0000;

  // apb answer: ready in the first access cycle
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup && !mapped;
      if (setup && !PWRITE) begin
        prdata_reg <= {16'h0000, rd_word};
      end
    end
  end

  // counter, period, divide and debug state
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      count_reg  <= {cdt_pkg::COUNT_RST, cdt_pkg::COUNT_RST};
      period_reg <= {cdt_pkg::PERIOD_HI_RST, cdt_pkg::PERIOD_LOW_RST};
      divide_reg <= cdt_pkg::DIVIDE_RST;
      emu_reg    <= cdt_pkg::EMU_RUN;
    end else begin
      count_reg  <= count_next;
      period_reg <= period_next;
      divide_reg <= divide_next;
      emu_reg    <= emu_next;
    end
  end

  // zero flag: set wins over a write-one clear
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      flag_reg <= cdt_pkg::CTRL_BIT_RST;
    end else if (zero_evt) begin
      flag_reg <= 1'b1;
    end else if (wr_tcr && wd[cdt_pkg::TCR_ZERO_FLAG]) begin
      flag_reg <= 1'b0;
    end
  end

  // control bits
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tie_reg  <= cdt_pkg::CTRL_BIT_RST;
      free_reg <= cdt_pkg::CTRL_BIT_RST;
      soft_reg <= cdt_pkg::CTRL_BIT_RST;
      tss_reg  <= cdt_pkg::CTRL_BIT_RST;
    end else if (wr_tcr) begin
      tie_reg  <= wd[cdt_pkg::TCR_IRQ_EN];
      free_reg <= wd[cdt_pkg::TCR_FREE_RUN];
      soft_reg <= wd[cdt_pkg::TCR_SOFT_STOP];
      tss_reg  <= wd[cdt_pkg::TCR_STOP];
    end
  end

  // one-cycle pulse, gated by irq enable
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pulse_reg <= 1'b0;
    end else begin
      pulse_reg <= zero_evt && tie_reg;
    end
  end

  assign PREADY          = pready_reg;
  assign PSLVERR         = pslverr_reg;
  assign PRDATA          = prdata_reg;
  assign TIMER_IRQ_PULSE = pulse_reg;

  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);

  property p_cnt_low;
    wr && h_cl && !reload |=> count_reg[15:0] == $past(wd);
  endproperty
  a_cnt_low: assert property (p_cnt_low) else $error("count low write lost");

  property p_decr;
    tick && count_reg != 32'h0000_0000 && !wr_cnt && !reload
      |=> count_reg == $past(count_reg) - 32'h0000_0001;
  endproperty
  a_decr: assert property (p_decr) else $error("count not decremented");

  property p_presc;
    tick && !wr_pre && !reload |=> psc_val == divide_reg;
  endproperty
  a_presc: assert property (p_presc) else $error("prescaler not reloaded");

  property p_pulse;
    zero_evt && tie_reg
      |=> TIMER_IRQ_PULSE ##1 (!TIMER_IRQ_PULSE || $past(zero_evt && tie_reg));
  endproperty
  a_pulse: assert property (p_pulse) else $error("missing timer pulse");

  property p_reload_zero;
    tick && count_reg == 32'h0000_0000 && !wr_cnt && !reload
      |=> count_reg == $past(period_reg);
  endproperty
  a_reload_zero: assert property (p_reload_zero) else $error("no period reload");

  property p_trigger;
    reload |=> count_reg == $past(period_reg);
  endproperty
  a_trigger: assert property (p_trigger) else $error("reload trigger ignored");

  property p_flag_set;
    zero_evt |=> flag_reg;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("zero flag not set");

  property p_flag_clr;
    wr_tcr && wd[cdt_pkg::TCR_ZERO_FLAG] && !zero_evt |=> !flag_reg;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("zero flag not cleared");

  property p_flag_keep;
    flag_reg && wr_tcr && !wd[cdt_pkg::TCR_ZERO_FLAG] |=> flag_reg;
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("zero flag lost");

  property p_no_irq;
    !tie_reg |=> !TIMER_IRQ_PULSE;
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("pulse while disabled");

  property p_held;
    emu_reg == cdt_pkg::EMU_HELD && DBG_HALT && !free_reg |-> !tick;
  endproperty
  a_held: assert property (p_held) else $error("ticks in debug hold");

  property p_stop;
    tss_reg && !wr_tcr |-> !tick [*2];
  endproperty
  a_stop: assert property (p_stop) else $error("ticks while stopped");
endmodule // cdt_timer

// >>> bench/testbench.sv
/*
  testbench: self-checking bench for the down-counting cpu timer.
  assumes: cdt_pkg and cdt_timer are compiled first; apb slave answers
  with zero wait states, but the master here still waits for pready.
*/
`timescale 1ns/1ps
module testbench;
  logic        ref_clk;  // 25 MHz clock
  logic        arst_n;   // async reset, active low
  logic        psel;     // apb select
  logic        penable;  // apb access phase
  logic        pwrite;   // apb direction
  logic [7:0]  paddr;    // apb byte address
  logic [31:0] pwdata;   // apb write data
  logic [31:0] prdata;   // apb read data
  logic        pready;   // apb ready
  logic        pslverr;  // apb error
  logic        dbg_halt; // debug halt level
  logic        tpulse;   // timer interrupt pulse
  logic        irq;      // level interrupt
  int          fails;    // mismatches
  int          compares; // comparisons made
  int          cycles;   // timeout counter
  logic [31:0] r;        // scratch read data

  cdt_timer uut (
    .REF_CLK(ref_clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .DBG_HALT(dbg_halt),
    .TIMER_IRQ_PULSE(tpulse), .IRQ(irq)
  );

  // free-running clock, 40 ns period
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // hang guard: far above the several hundred cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (fails == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // byte address of a register word index
  function automatic logic [7:0] ad(input logic [3:0] i);
    return {2'b00, i, 2'b00};
  endfunction

  // one control bit as a word
  function automatic logic [31:0] bv(input int b);
    return 32'h0000_0001 << b;
  endfunction

  // one apb transfer: setup, then access held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd_v, output logic err);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // no timeout here: pready or the bench hang guard ends this wait
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic        e;
    apb(1'b1, a, d, x, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic e;
    apb(1'b0, a, 32'h0000_0000, v, e);
  endtask

  // cycles until the next pulse, bounded
  task automatic wait_pulse(output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (tpulse !== 1'b1 && n < 200);
  endtask

  // reset values of the register table
  task automatic t_reset_values();
    rd(ad(cdt_pkg::IDX_PERIOD_LOW), r); chk(r, 32'h0000_FFFF);
    rd(ad(cdt_pkg::IDX_PERIOD_HI), r);  chk(r, 32'h0000_0000);
    rd(ad(cdt_pkg::IDX_CONTROL), r);    chk(r, 32'h0000_0000);
    rd(ad(cdt_pkg::IDX_IRQ_STATUS), r); chk(r, 32'h0000_0000);
    rd(ad(cdt_pkg::IDX_IRQ_ENABLE), r); chk(r, 32'h0000_0000);
  endtask

  // halves read back while stopped; unmapped and read-only places
  task automatic t_rw();
    logic e;
    wr(ad(cdt_pkg::IDX_CONTROL), bv(cdt_pkg::TCR_STOP));
    wr(ad(cdt_pkg::IDX_COUNT_LOW), 32'h0000_1234);
    wr(ad(cdt_pkg::IDX_COUNT_HIGH), 32'h0000_5678);
    wr(ad(cdt_pkg::IDX_PERIOD_LOW), 32'h0000_9ABC);
    wr(ad(cdt_pkg::IDX_PERIOD_HI), 32'h0000_DEF0);
    repeat (20) @(posedge ref_clk);
    rd(ad(cdt_pkg::IDX_COUNT_LOW), r);  chk(r, 32'h0000_1234);
    rd(ad(cdt_pkg::IDX_COUNT_HIGH), r); chk(r, 32'h0000_5678);
    rd(ad(cdt_pkg::IDX_PERIOD_LOW), r); chk(r, 32'h0000_9ABC);
    rd(ad(cdt_pkg::IDX_PERIOD_HI), r);  chk(r, 32'h0000_DEF0);
    apb(1'b1, 8'h14, 32'h0000_FFFF, r, e);
    chk(32'(e), 32'h0000_0001);
    apb(1'b0, 8'h40, 32'h0000_0000, r, e);
    chk(32'(e), 32'h0000_0001);
    chk(r, 32'h0000_0000);
    wr(ad(cdt_pkg::IDX_IRQ_STATUS), 32'h0000_0003);
    rd(ad(cdt_pkg::IDX_IRQ_STATUS), r); chk(r, 32'h0000_0000);
  endtask

  // pulse spacing, flag, interrupt status, mask and clear
  task automatic t_period();
    int n;
    wr(ad(cdt_pkg::IDX_PRESC_LOW), 32'h0000_0004);
    wr(ad(cdt_pkg::IDX_PERIOD_LOW), 32'h0000_0001);
    wr(ad(cdt_pkg::IDX_PERIOD_HI), 32'h0000_0000);
    wr(ad(cdt_pkg::IDX_COUNT_LOW), 32'h0000_0001);
    wr(ad(cdt_pkg::IDX_COUNT_HIGH), 32'h0000_0000);
    wr(ad(cdt_pkg::IDX_IRQ_ENABLE), 32'h0000_0001);
    wr(ad(cdt_pkg::IDX_CONTROL), bv(cdt_pkg::TCR_IRQ_EN));
    wait_pulse(n);
    chk(32'(tpulse), 32'h0000_0001);
    wait_pulse(n);
    chk(n, 10);
    wr(ad(cdt_pkg::IDX_CONTROL), bv(cdt_pkg::TCR_STOP) | bv(cdt_pkg::TCR_IRQ_EN));
    rd(ad(cdt_pkg::IDX_CONTROL), r);
    chk(r, bv(15) | bv(14) | bv(4));
    wr(ad(cdt_pkg::IDX_CONTROL), bv(cdt_pkg::TCR_STOP) | bv(cdt_pkg::TCR_IRQ_EN));
    rd(ad(cdt_pkg::IDX_CONTROL), r);
    chk(r, bv(15) | bv(14) | bv(4));
    wr(ad(cdt_pkg::IDX_CONTROL), bv(cdt_pkg::TCR_STOP) | bv(cdt_pkg::TCR_ZERO_FLAG));
    rd(ad(cdt_pkg::IDX_CONTROL), r);
    chk(r, bv(4));
    rd(ad(cdt_pkg::IDX_IRQ_STATUS), r); chk(r, 32'h0000_0001);
    chk(32'(irq), 32'h0000_0001);
    wr(ad(cdt_pkg::IDX_IRQ_ENABLE), 32'h0000_0000);
    repeat (2) @(posedge ref_clk);
    chk(32'(irq), 32'h0000_0000);
    wr(ad(cdt_pkg::IDX_IRQ_ENABLE), 32'h0000_0001);
    repeat (2) @(posedge ref_clk);
    chk(32'(irq), 32'h0000_0001);
    wr(ad(cdt_pkg::IDX_IRQ_CLEAR), 32'h0000_0001);
    repeat (2) @(posedge ref_clk);
    chk(32'(irq), 32'h0000_0000);
    rd(ad(cdt_pkg::IDX_IRQ_STATUS), r); chk(r, 32'h0000_0000);
  endtask

  // zero crossings with irq_enable low: flag yes, pulse no
  task automatic t_no_irq();
    int n;
    wr(ad(cdt_pkg::IDX_CONTROL), 32'h0000_0000);
    wait_pulse(n);
    chk(n, 200);
    wr(ad(cdt_pkg::IDX_CONTROL), bv(cdt_pkg::TCR_STOP));
    rd(ad(cdt_pkg::IDX_CONTROL), r); chk(r, bv(15) | bv(4));
    rd(ad(cdt_pkg::IDX_IRQ_STATUS), r); chk(r, 32'h0000_0000);
  endtask

  // reload trigger copies the whole period
  task automatic t_reload();
    wr(ad(cdt_pkg::IDX_PERIOD_LOW), 32'h0000_AAAA);
    wr(ad(cdt_pkg::IDX_PERIOD_HI), 32'h0000_5555);
    wr(ad(cdt_pkg::IDX_CONTROL), bv(cdt_pkg::TCR_STOP) | bv(cdt_pkg::TCR_RELOAD));
    rd(ad(cdt_pkg::IDX_COUNT_LOW), r);  chk(r, 32'h0000_AAAA);
    rd(ad(cdt_pkg::IDX_COUNT_HIGH), r); chk(r, 32'h0000_5555);
    rd(ad(cdt_pkg::IDX_CONTROL), r);    chk(r, bv(15) | bv(4));
  endtask

  // debug halt: hard stop, soft stop at zero, free run
  task automatic t_debug();
    logic [31:0] r2;
    wr(ad(cdt_pkg::IDX_PRESC_LOW), 32'h0000_0000);
    wr(ad(cdt_pkg::IDX_COUNT_LOW), 32'h0000_0064);
    wr(ad(cdt_pkg::IDX_COUNT_HIGH), 32'h0000_0000);
    wr(ad(cdt_pkg::IDX_CONTROL), 32'h0000_0000);
    dbg_halt <= 1'b1;
    repeat (5) @(posedge ref_clk);
    rd(ad(cdt_pkg::IDX_COUNT_LOW), r);
    repeat (10) @(posedge ref_clk);
    rd(ad(cdt_pkg::IDX_COUNT_LOW), r2);
    chk(r2, r);
    rd(ad(cdt_pkg::IDX_IRQ_STATUS), r); chk(r, 32'h0000_0002);
    wr(ad(cdt_pkg::IDX_CONTROL), bv(cdt_pkg::TCR_SOFT_STOP));
    dbg_halt <= 1'b0;
    repeat (3) @(posedge ref_clk);
    dbg_halt <= 1'b1;
    repeat (200) @(posedge ref_clk);
    rd(ad(cdt_pkg::IDX_COUNT_LOW), r);  chk(r, 32'h0000_0000);
    rd(ad(cdt_pkg::IDX_COUNT_HIGH), r); chk(r, 32'h0000_0000);
    wr(ad(cdt_pkg::IDX_CONTROL), bv(cdt_pkg::TCR_SOFT_STOP) | bv(cdt_pkg::TCR_FREE_RUN));
    repeat (5) @(posedge ref_clk);
    rd(ad(cdt_pkg::IDX_COUNT_HIGH), r); chk(r, 32'h0000_5555);
    rd(ad(cdt_pkg::IDX_COUNT_LOW), r);
    rd(ad(cdt_pkg::IDX_COUNT_LOW), r2);
    chk(32'(r2 != r), 32'h0000_0001);
    dbg_halt <= 1'b0;
  endtask

  // main sequence
  initial begin
    fails    = 0;
    compares = 0;
    cycles   = 0;
    arst_n   = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h0000_0000;
    dbg_halt = 1'b0;
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_reset_values();
    t_rw();
    t_period();
    t_no_irq();
    t_reload();
    t_debug();
    report_and_stop();
  end
endmodule // testbench
